/* File: rtl/uis_params.svh */
`ifndef UIS_PARAMS_SVH
`define UIS_PARAMS_SVH

// byte offsets
`define UIS_OFS_STATUS 8'h14
`define UIS_OFS_MASK 8'h18
`define UIS_OFS_RX_PEEK 8'h1C
`define UIS_OFS_RX_POP 8'h1C

// status bit positions
`define UIS_BIT_ROLE 0
`define UIS_BIT_MISMATCH 1
`define UIS_BIT_OTG 2
`define UIS_BIT_SOF 3
`define UIS_BIT_RX_LEVEL 4
`define UIS_BIT_TX_EMPTY 5
`define UIS_BIT_IN_NAK 6
`define UIS_BIT_OUT_NAK 7
`define UIS_BIT_EARLY_SUSP 10
`define UIS_BIT_SUSPEND 11
`define UIS_BIT_BUS_RESET 12
`define UIS_BIT_ENUM_DONE 13
`define UIS_BIT_ISO_DROP 14
`define UIS_BIT_PERIODIC 15
`define UIS_BIT_IN_EP 18
`define UIS_BIT_OUT_EP 19

// rx status fields
`define UIS_FN_HI 24
`define UIS_FN_LO 21
`define UIS_PACKET_STATUS_HI 20
`define UIS_PACKET_STATUS_LO 17
`define UIS_DATA_PID_FIELD_HI 16
`define UIS_DATA_PID_FIELD_LO 15
`define UIS_BYTE_COUNT_HI 14
`define UIS_BYTE_COUNT_LO 4
`define UIS_ENDPOINT_NUMBER_HI 3
`define UIS_ENDPOINT_NUMBER_LO 0

// reset values, masks
`define UIS_MASK_RESET 32'h00000000
`define UIS_MASK_WRITABLE 32'hFFFEFCFE
`define UIS_STATUS_W1C 32'h0000FC0E
`define UIS_RX_RESET 32'h00000000

// timing
`define UIS_CLK_KHZ 125000
`define UIS_EARLY_SUSP_MS 3
`define UIS_SUSPEND_MS 6

// idle line state
`define UIS_LINE_IDLE 2'h1

`endif

/* File: rtl/uis_pkg.sv */
package uis_pkg;
    // suspend tracking, one-hot
    typedef enum logic [2:0] {
        UIS_ACTIVE = 3'b001,
        UIS_EARLY = 3'b010,
        UIS_SUSPENDED = 3'b100
    } uis_susp_state_t;

    // packet status codes of the receive status word
    typedef enum logic [3:0] {
        UIS_PKT_OUT_NAK = 4'h1,
        UIS_PKT_OUT_DATA = 4'h2,
        UIS_PKT_OUT_DONE = 4'h3,
        UIS_PKT_SETUP_DONE = 4'h4,
        UIS_PKT_SETUP_DATA = 4'h6
    } uis_pkt_status_t;

    // data pid codes
    typedef enum logic [1:0] {
        UIS_PID_DATA0 = 2'h0,
        UIS_PID_DATA2 = 2'h1,
        UIS_PID_DATA1 = 2'h2,
        UIS_PID_MDATA = 2'h3
    } uis_data_pid_t;

    typedef logic [31:0] uis_word_t;
endpackage

/* File: rtl/uis_status_queue.sv */
`timescale 1ns/10ps
// rx status word queue in flops
module uis_status_queue #(
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk_sys, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic push, // store one word
    input wire uis_pkg::uis_word_t push_word, // word to store
    input wire logic pop, // remove head word
    output uis_pkg::uis_word_t head_word, // oldest word
    output logic not_empty, // at least one word held
    output logic not_full // room for one more word
);
    import uis_pkg::*;

    uis_word_t store [DEPTH]; // status storage
    logic [AW-1:0] wr_idx; // write index
    logic [AW-1:0] rd_idx; // read index
    logic [AW:0] count; // words held
    logic do_push; // push accepted
    logic do_pop; // pop accepted

    // a push into a full queue is dropped; the source must watch not_full
    assign do_push = push && not_full;
    assign do_pop = pop && not_empty;
    assign head_word = store[rd_idx];

    // storage writes
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                store[i] <= '0;
            end
        end else if (do_push) begin
            store[wr_idx] <= push_word;
        end
    end

    // indices and fill level
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_idx <= '0;
            rd_idx <= '0;
            count <= '0;
            not_empty <= 1'b0;
            not_full <= 1'b1;
        end else begin
            if (do_push) begin
                wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
            end
            if (do_pop) begin
                rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
            end
            // flags as flops for clean ports
            unique case ({do_push, do_pop})
                2'b10: begin
                    count <= count + 1'b1;
                    not_empty <= 1'b1;
                    not_full <= (count != (AW+1)'(DEPTH - 1));
                end
                2'b01: begin
                    count <= count - 1'b1;
                    not_empty <= (count != (AW+1)'(1));
                    not_full <= 1'b1;
                end
                default: begin
                    count <= count;
                end
            endcase
        end
    end
endmodule

/* File: rtl/uis_core.sv */
`timescale 1ns/10ps
`include "uis_params.svh"
// Operation
// R1: flag periodic frame interval point reached
// R2: flag iso OUT packet dropped, no room
// R3: flag speed enumeration done; speed elsewhere
// R4: flag bus reset detected
// R5: flag suspend and enter suspended after idle
// R6: flag early suspend after 3 ms idle
// R7: out NAK effective until clear written
// R8: in NAK effective once request sampled
// R9: tx empty flag per level, queue space
// R10: rx level while status entries unread
// R11: flag SOF in device mode, HS/FS
// R12: OTG flag, cleared through OTG register; here bit 2 is sticky and cleared by writing one
// R13: flag wrong-role register access, no effect
// R14: bit 0 reports role, resets to host
// R15: software clears IN cause per endpoint
// R16: mask bit 1 unmasks; reset all zero
// R17: frame number low bits in status word
// R18: packet status codes in bits 20:17
// R19: data PID code in bits 16:15
// R20: byte count in bits 14:4
// R21: endpoint number in bits 3:0
// R22: software clears OUT cause per endpoint
// R23: set-by-core bits cleared by writing one
// R24: peek keeps entry, pop removes entry
module uis_core #(
    parameter int EARLY_SUSP_CYCLES =
        `UIS_EARLY_SUSP_MS * `UIS_CLK_KHZ, // idle cycles to early suspend
    parameter int SUSPEND_CYCLES =
        `UIS_SUSPEND_MS * `UIS_CLK_KHZ, // idle cycles to suspend
    parameter int RX_DEPTH = 8, // receive status entries
    parameter int RX_AW = 3, // index width for RX_DEPTH
    parameter int TX_FIFO_WORDS = 256, // non-periodic tx fifo size
    parameter bit DEDICATED_TX_FIFO = 1'b0, // dedicated_tx_fifo_option
    parameter bit ISO_OUT_SUPPORT = 1'b1 // frame number field kept
) (
    input wire logic clk_sys, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic [7:0] reg_addr, // register byte address
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic reg_pop, // read at 0x1C pops
    input wire logic reg_host_space, // host register access
    input wire logic reg_dev_space, // device register access
    input wire uis_pkg::uis_word_t reg_wdata, // write data
    output uis_pkg::uis_word_t reg_rdata, // read data
    output logic reg_rvalid, // read valid
    input wire logic role_host, // core runs in host role
    input wire logic periodic_frame_point, // frame point
    input wire logic iso_out_drop, // iso drop
    input wire logic enum_done, // enum done
    input wire logic bus_reset_seen, // bus reset
    input wire logic sof_received, // SOF seen
    input wire logic low_speed, // low speed
    input wire logic otg_pending, // OTG cause
    input wire logic in_endpoint_pending, // IN cause
    input wire logic out_endpoint_pending, // OUT cause
    input wire logic set_global_out_nak, // set out nak
    input wire logic clear_global_out_nak, // clear out nak pulse
    input wire logic set_global_in_nak, // set in nak request pulse
    input wire logic clear_global_in_nak, // clear in nak pulse
    input wire logic rx_busy, // rx mid-packet
    input wire logic tx_empty_level_select, // 1: fully empty, 0: half
    input wire logic [15:0] tx_fifo_free, // free tx fifo words
    input wire logic [7:0] tx_queue_free, // free request queue entries
    input wire logic [1:0] phy_line_state, // line state pin
    input wire logic rx_push, // rx entry push
    input wire logic [3:0] frame_number_low, // frame low bits
    input wire uis_pkg::uis_pkt_status_t packet_status, // packet status
    input wire uis_pkg::uis_data_pid_t data_pid_field, // data pid
    input wire logic [10:0] byte_count, // packet byte count
    input wire logic [3:0] endpoint_number, // endpoint of packet
    output logic rx_push_ready, // queue room
    output logic suspended, // suspended
    output uis_pkg::uis_word_t global_irq_pending // status and mask
);
    import uis_pkg::*;

    localparam int IDLE_W = 32; // idle counter width

    uis_word_t global_irq_status; // sticky and live status
    uis_word_t global_irq_mask; // mask, 1 unmasks
    uis_word_t status_set; // set terms
    uis_word_t status_w1c; // clear terms
    uis_word_t status_live; // read-only live bits
    uis_word_t rx_word; // new rx entry
    uis_word_t rx_head; // oldest rx entry
    logic rx_not_empty; // queue holds an entry
    logic rx_pop; // pop request to the queue
    logic [1:0] ls_s1; // sync 1
    logic [1:0] ls_s2; // sync 2
    logic [1:0] ls_s3; // sync 3
    logic [1:0] line_state; // agreed line state
    logic [IDLE_W-1:0] idle_count; // idle cycles
    uis_susp_state_t susp_state; // suspend tracking
    uis_susp_state_t next_susp_state; // next suspend tracking
    logic early_hit; // early point
    logic susp_hit; // suspend point
    logic out_nak_req; // out nak pending
    logic out_nak_effective_flag; // out nak in effect
    logic in_nak_effective_flag; // in nak sampled
    logic nonperiodic_tx_empty_flag; // tx empty status
    logic current_role; // role shown in bit 0
    logic wrong_role; // wrong-role access
    logic wr_status; // status write
    logic wr_mask; // mask write

    // address decode for reads and writes
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    // wrong-role access completes with no effect
    assign wrong_role = (reg_wr || reg_rd) &&
        ((reg_host_space && !current_role) ||
         (reg_dev_space && current_role)); // R13
    assign wr_status = reg_wr && !wrong_role &&
        hit(reg_addr, `UIS_OFS_STATUS);
    assign wr_mask = reg_wr && !wrong_role && hit(reg_addr, `UIS_OFS_MASK);
    assign rx_pop = reg_rd && reg_pop && !wrong_role &&
        hit(reg_addr, `UIS_OFS_RX_POP); // R24

    // line state pin: three flops, stages 2 and 3 must agree
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ls_s1 <= `UIS_LINE_IDLE;
            ls_s2 <= `UIS_LINE_IDLE;
            ls_s3 <= `UIS_LINE_IDLE;
            line_state <= `UIS_LINE_IDLE;
        end else begin
            ls_s1 <= phy_line_state;
            ls_s2 <= ls_s1;
            ls_s3 <= ls_s2;
            if (ls_s2 == ls_s3) begin
                line_state <= ls_s3;
            end
        end
    end

    // idle time; saturates so a long suspend cannot wrap and re-trigger
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            idle_count <= '0;
        end else if (line_state != `UIS_LINE_IDLE) begin
            idle_count <= '0; // activity restarts
        end else if (idle_count != IDLE_W'(SUSPEND_CYCLES)) begin
            idle_count <= idle_count + 1'b1;
        end
    end

    assign early_hit = (idle_count == IDLE_W'(EARLY_SUSP_CYCLES - 1)); // R6
    assign susp_hit = (idle_count == IDLE_W'(SUSPEND_CYCLES - 1)); // R5

    // suspend tracking state
    always_comb begin
        next_susp_state = susp_state;
        unique case (susp_state)
            UIS_ACTIVE: begin
                if (early_hit) begin
                    next_susp_state = UIS_EARLY; // R6
                end
            end
            UIS_EARLY: begin
                if (line_state != `UIS_LINE_IDLE) begin
                    next_susp_state = UIS_ACTIVE;
                end else if (susp_hit) begin
                    next_susp_state = UIS_SUSPENDED; // R5
                end
            end
            UIS_SUSPENDED: begin
                if (line_state != `UIS_LINE_IDLE) begin
                    next_susp_state = UIS_ACTIVE; // resume on activity
                end
            end
            default: begin
                next_susp_state = UIS_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            susp_state <= UIS_ACTIVE;
            suspended <= 1'b0;
        end else begin
            susp_state <= next_susp_state;
            suspended <= (next_susp_state == UIS_SUSPENDED); // R5
        end
    end

    // out nak: waits until rx is between packets
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            out_nak_req <= 1'b0;
            out_nak_effective_flag <= 1'b0;
        end else if (clear_global_out_nak) begin
            out_nak_req <= 1'b0; // R7
            out_nak_effective_flag <= 1'b0; // R7
        end else if (set_global_out_nak || out_nak_req) begin
            out_nak_req <= rx_busy;
            if (!rx_busy) begin
                out_nak_effective_flag <= 1'b1; // R7
            end
        end
    end

    // in nak: effective once sampled
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            in_nak_effective_flag <= 1'b0;
        end else if (clear_global_in_nak) begin
            in_nak_effective_flag <= 1'b0;
        end else if (set_global_in_nak) begin
            in_nak_effective_flag <= 1'b1; // R8
        end
    end

    // tx empty; held low with dedicated fifos
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            nonperiodic_tx_empty_flag <= 1'b1; // R9
        end else if (DEDICATED_TX_FIFO) begin
            nonperiodic_tx_empty_flag <= 1'b0;
        end else begin
            nonperiodic_tx_empty_flag <= (tx_queue_free != 8'h00) &&
                (tx_empty_level_select ?
                 (tx_fifo_free == 16'(TX_FIFO_WORDS)) :
                 (tx_fifo_free >= 16'(TX_FIFO_WORDS / 2))); // R9
        end
    end

    // role bit: host at reset, then follows the core
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            current_role <= 1'b1; // R14
        end else begin
            current_role <= role_host; // R14
        end
    end

    // sticky set terms
    always_comb begin
        status_set = '0;
        status_set[`UIS_BIT_PERIODIC] = periodic_frame_point; // R1
        status_set[`UIS_BIT_ISO_DROP] = iso_out_drop; // R2
        status_set[`UIS_BIT_ENUM_DONE] = enum_done; // R3
        status_set[`UIS_BIT_BUS_RESET] = bus_reset_seen; // R4
        status_set[`UIS_BIT_SUSPEND] = susp_hit &&
            (susp_state == UIS_EARLY); // R5
        status_set[`UIS_BIT_EARLY_SUSP] = early_hit &&
            (susp_state == UIS_ACTIVE); // R6
        status_set[`UIS_BIT_SOF] = sof_received && !current_role &&
            !low_speed; // R11
        // re-sets while the OTG cause is pending
        status_set[`UIS_BIT_OTG] = otg_pending; // R12
        status_set[`UIS_BIT_MISMATCH] = wrong_role; // R13
    end

    // write-one-clear; zero leaves a bit alone
    assign status_w1c = wr_status ? (reg_wdata & `UIS_STATUS_W1C) : '0; // R23

    // read-only live bits
    always_comb begin
        status_live = '0;
        status_live[`UIS_BIT_ROLE] = current_role; // R14
        status_live[`UIS_BIT_RX_LEVEL] = rx_not_empty; // R10
        status_live[`UIS_BIT_TX_EMPTY] = nonperiodic_tx_empty_flag; // R9
        status_live[`UIS_BIT_IN_NAK] = in_nak_effective_flag; // R8
        status_live[`UIS_BIT_OUT_NAK] = out_nak_effective_flag; // R7
        // endpoint bits clear at the endpoint registers
        status_live[`UIS_BIT_IN_EP] = in_endpoint_pending; // R15
        status_live[`UIS_BIT_OUT_EP] = out_endpoint_pending; // R22
    end

    // status register; a set in the clear cycle wins
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            global_irq_status <= '0;
            global_irq_status[`UIS_BIT_ROLE] <= 1'b1;
            global_irq_status[`UIS_BIT_TX_EMPTY] <= 1'b1;
        end else begin
            global_irq_status <= (((global_irq_status & `UIS_STATUS_W1C) &
                ~status_w1c) | status_set) | status_live; // R23
        end
    end

    // mask register; reserved bits stay zero
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            global_irq_mask <= `UIS_MASK_RESET; // R16
        end else if (wr_mask) begin
            global_irq_mask <= reg_wdata & `UIS_MASK_WRITABLE; // R16
        end
    end

    // masked view for the interrupt logic
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            global_irq_pending <= '0;
        end else begin
            global_irq_pending <= global_irq_status & global_irq_mask; // R16
        end
    end

    // rx status word
    always_comb begin
        rx_word = `UIS_RX_RESET;
        if (ISO_OUT_SUPPORT) begin
            rx_word[`UIS_FN_HI:`UIS_FN_LO] = frame_number_low; // R17
        end
        rx_word[`UIS_PACKET_STATUS_HI:`UIS_PACKET_STATUS_LO] = packet_status; // R18
        rx_word[`UIS_DATA_PID_FIELD_HI:`UIS_DATA_PID_FIELD_LO] = data_pid_field; // R19
        rx_word[`UIS_BYTE_COUNT_HI:`UIS_BYTE_COUNT_LO] = byte_count; // R20
        rx_word[`UIS_ENDPOINT_NUMBER_HI:`UIS_ENDPOINT_NUMBER_LO] = endpoint_number; // R21
    end

    uis_status_queue #(
        .DEPTH(RX_DEPTH),
        .AW(RX_AW)
    ) u_rx_queue (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .push(rx_push),
        .push_word(rx_word),
        .pop(rx_pop), // R24
        .head_word(rx_head),
        .not_empty(rx_not_empty), // R10
        .not_full(rx_push_ready)
    );

    // reads, answered a cycle after the strobe
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                if (wrong_role) begin
                    reg_rdata <= '0; // ignored inside
                end else if (hit(reg_addr, `UIS_OFS_STATUS)) begin
                    reg_rdata <= global_irq_status;
                end else if (hit(reg_addr, `UIS_OFS_MASK)) begin
                    reg_rdata <= global_irq_mask;
                end else if (hit(reg_addr, `UIS_OFS_RX_PEEK)) begin
                    // empty queue reads as zero; peek and pop share data
                    reg_rdata <= rx_not_empty ? rx_head : '0; // R24
                end else begin
                    reg_rdata <= '0; // unmapped reads as zero
                end
            end
        end
    end
endmodule

/* File: verif/uis_core_properties.sv */
`timescale 1ns/10ps
// register and status checks
module uis_core_properties (
    input wire logic clk_sys, // clock
    input wire logic reset_n, // reset, active low
    input wire logic [7:0] reg_addr, // address
    input wire logic reg_wr, // write
    input wire logic reg_rd, // read
    input wire logic reg_pop, // pop
    input wire logic reg_host_space, // host access
    input wire logic reg_dev_space, // device access
    input wire uis_pkg::uis_word_t reg_wdata, // write data
    input wire uis_pkg::uis_word_t reg_rdata, // read data
    input wire logic reg_rvalid, // read valid
    input wire logic role_host, // role
    input wire logic rx_push, // status push
    input wire logic [1:0] phy_line_state, // line state
    input wire logic suspended, // suspended
    input wire uis_pkg::uis_word_t global_irq_pending // pending
);
    import uis_pkg::*;
    // normal-role accesses only
    logic peek_rd;
    logic mask_wr;
    assign peek_rd = reg_rd && reg_addr == 8'h1C && !reg_pop &&
        !reg_host_space && !reg_dev_space;
    assign mask_wr = reg_wr && reg_addr == 8'h18 &&
        !reg_host_space && !reg_dev_space;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    rvalid_timing_a: assert property (reg_rvalid == $past(reg_rd))
        else $error("late read valid");
    reserved_zero_a: assert property (
        (global_irq_pending & 32'hFFF30301) == 32'h0)
        else $error("reserved pending bit set");
    mask_readback_a: assert property (mask_wr ##1 !reg_wr ##1 reg_rd &&
        reg_addr == 8'h18 |=> reg_rdata == ($past(reg_wdata, 3) & 32'hFFFEFCFE))
        else $error("mask read back wrong");
    mask_gate_a: assert property (mask_wr && reg_wdata == 32'h0
        ##1 !reg_wr |=> global_irq_pending == 32'h0)
        else $error("masked bit pending");
    peek_keep_a: assert property (peek_rd && !rx_push ##1 !reg_rd &&
        !rx_push ##1 peek_rd |=> reg_rdata == $past(reg_rdata, 2))
        else $error("peek changed head");
    mismatch_read_a: assert property (reg_rd && reg_host_space &&
        !role_host && $stable(role_host) |=> reg_rvalid && reg_rdata == 32'h0)
        else $error("wrong-role read data");
    role_bit_a: assert property (reg_rd && reg_addr == 8'h14 &&
        !reg_host_space && !reg_dev_space && $past(reset_n)
        |=> reg_rdata[0] == $past(role_host, 3))
        else $error("role bit wrong");
    suspend_idle_a: assert property ($rose(suspended)
        |-> $past(phy_line_state, 8) == 2'h1)
        else $error("suspend without idle");

    // main scenarios reached
    cover property (peek_rd);
    cover property (reg_rd && reg_pop);
    cover property ($rose(suspended));
endmodule

bind uis_core uis_core_properties props (.*);

/* File: verif/uis_usb_peer.sv */
`timescale 1ns/10ps
// far-side peer: activity, SOF, bus reset
module uis_usb_peer (
    input wire logic clk_sys, // clock
    input wire logic idle_req, // leave bus idle
    input wire logic sof_req, // send one SOF
    input wire logic rst_req, // signal a bus reset
    output logic [1:0] phy_line_state, // line state to core
    output logic sof_received, // SOF pulse
    output logic bus_reset_seen // bus reset pulse
);
    initial phy_line_state = 2'h2;
    initial sof_received = 1'b0;
    initial bus_reset_seen = 1'b0;
    // busy bus holds a steady non-idle state the synchroniser can agree on
    always @(posedge clk_sys) begin
        phy_line_state <= idle_req ? 2'h1 : 2'h2;
        sof_received <= sof_req;
        bus_reset_seen <= rst_req;
    end
endmodule

/* File: verif/tb.sv */
`timescale 1ns/10ps
// compare and count
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    import uis_pkg::*;
    logic clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic reg_pop = 1'b0, reg_host_space = 1'b0, reg_dev_space = 1'b0;
    logic role_host = 1'b0, low_speed = 1'b0, otg_pending = 1'b0;
    logic in_endpoint_pending = 1'b0, out_endpoint_pending = 1'b0;
    logic rx_busy = 1'b0, tx_empty_level_select = 1'b0, rx_push = 1'b0;
    logic idle_req = 1'b0, reg_rvalid, rx_push_ready, suspended;
    logic sof_received, bus_reset_seen;
    logic [8:0] ev = 9'h000; // event pulses
    logic [7:0] reg_addr = 8'h00, tx_queue_free = 8'h01;
    logic [15:0] tx_fifo_free = 16'h0100; // fifo fully free
    logic [1:0] phy_line_state;
    logic [3:0] frame_number_low = 4'h0, endpoint_number = 4'h0;
    logic [10:0] byte_count = 11'h000;
    uis_pkt_status_t packet_status = UIS_PKT_OUT_NAK;
    uis_data_pid_t data_pid_field = UIS_PID_DATA0;
    uis_word_t reg_wdata = 32'h0, reg_rdata, global_irq_pending;
    int num_errors = 0, checks = 0;

    // short suspend counts keep the run brief
    uis_core #(.EARLY_SUSP_CYCLES(20), .SUSPEND_CYCLES(40)) DUT (.clk_sys,
        .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_pop, .reg_host_space,
        .reg_dev_space, .reg_wdata, .reg_rdata, .reg_rvalid, .role_host,
        .periodic_frame_point(ev[0]), .iso_out_drop(ev[1]),
        .enum_done(ev[2]), .bus_reset_seen, .sof_received, .low_speed,
        .otg_pending, .in_endpoint_pending, .out_endpoint_pending,
        .set_global_out_nak(ev[5]), .clear_global_out_nak(ev[6]),
        .set_global_in_nak(ev[7]), .clear_global_in_nak(ev[8]), .rx_busy,
        .tx_empty_level_select, .tx_fifo_free, .tx_queue_free,
        .phy_line_state, .rx_push, .frame_number_low, .packet_status,
        .data_pid_field, .byte_count, .endpoint_number, .rx_push_ready,
        .suspended, .global_irq_pending);
    uis_usb_peer peer (.clk_sys, .idle_req, .sof_req(ev[4]),
        .rst_req(ev[3]), .phy_line_state, .sof_received, .bus_reset_seen);

    always #4 clk_sys = ~clk_sys;

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input uis_word_t d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // read; sp = {host, device} space flags
    task automatic rd(input logic [7:0] a, input logic p, input uis_word_t e,
        input logic [1:0] sp = 2'b00);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_pop <= p;
        {reg_host_space, reg_dev_space} <= sp;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        {reg_host_space, reg_dev_space} <= 2'b00;
        #1;
        `CHK({reg_rvalid, reg_rdata}, {1'b1, e})
    endtask
    task automatic rs(input uis_word_t e);
        rd(8'h14, 1'b0, e);
    endtask
    task automatic pulse(input logic [8:0] m);
        @(posedge clk_sys);
        ev <= m;
        @(posedge clk_sys);
        ev <= 9'h000;
        tick(2);
    endtask
    // entry i: one per packet code
    function automatic uis_word_t rx_word(input int i);
        rx_word = {7'h00, 4'(i + 9), 4'(20'h64321 >> (4 * i)),
            2'(10'h0D8 >> (2 * i)), 11'h7FF - 11'(i), 4'(3 * i)};
    endfunction
    task automatic stop_test();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        tick(4);
        reset_n <= 1'b1;
        rd(8'h18, 1'b0, 32'h0);
        rs(32'h20);
        wr(8'h18, 32'hFFFFFFFF);
        rd(8'h18, 1'b0, 32'hFFFEFCFE);
        // five sticky events, then write-one clear
        pulse(9'h01F);
        rs(32'hF028);
        `CHK(global_irq_pending, 32'hF028)
        wr(8'h14, 32'h0);
        rs(32'hF028);
        wr(8'h14, 32'hF008);
        rs(32'h20);
        @(posedge clk_sys) low_speed <= 1'b1;
        pulse(9'h010);
        rs(32'h20);
        @(posedge clk_sys) low_speed <= 1'b0;
        pulse(9'h0A0);
        rs(32'hE0);
        pulse(9'h140);
        rs(32'h20);
        @(posedge clk_sys);
        {otg_pending, in_endpoint_pending, out_endpoint_pending} <= 3'h7;
        tick(2);
        rs(32'hC0024);
        @(posedge clk_sys);
        {otg_pending, in_endpoint_pending, out_endpoint_pending} <= 3'h0;
        wr(8'h14, 32'h4);
        rs(32'h20);
        @(posedge clk_sys) tx_queue_free <= 8'h00;
        tick(2);
        rs(32'h0);
        @(posedge clk_sys) tx_queue_free <= 8'h01;
        rd(8'h14, 1'b0, 32'h0, 2'b10);
        rs(32'h22);
        wr(8'h14, 32'h2);
        @(posedge clk_sys) role_host <= 1'b1;
        tick(2);
        rs(32'h21);
        @(posedge clk_sys) role_host <= 1'b0;
        // push five, peek twice, pop all
        for (int i = 0; i < 5; i++) begin
            uis_word_t w;
            w = rx_word(i);
            @(posedge clk_sys);
            rx_push <= 1'b1;
            frame_number_low <= w[24:21];
            packet_status <= uis_pkt_status_t'(w[20:17]);
            data_pid_field <= uis_data_pid_t'(w[16:15]);
            byte_count <= w[14:4];
            endpoint_number <= w[3:0];
        end
        @(posedge clk_sys) rx_push <= 1'b0;
        tick(2);
        `CHK(rx_push_ready, 1'b1)
        rs(32'h30);
        rd(8'h1C, 1'b0, rx_word(0));
        rd(8'h1C, 1'b0, rx_word(0));
        for (int i = 0; i < 5; i++) begin
            rd(8'h1C, 1'b1, rx_word(i));
        end
        tick(2);
        rs(32'h20);
        // idle bus: early flag, then suspend
        @(posedge clk_sys) idle_req <= 1'b1;
        for (int n = 0; n < 200 && suspended !== 1'b1; n++) tick(1);
        if (suspended !== 1'b1) begin
            num_errors++;
            stop_test();
        end
        rs(32'hC20);
        @(posedge clk_sys) idle_req <= 1'b0;
        wr(8'h14, 32'hC00);
        tick(8);
        `CHK(suspended, 1'b0)
        rs(32'h20);
        wr(8'h18, 32'h0);
        tick(2);
        `CHK(global_irq_pending, 32'h0)
        stop_test();
    end
endmodule
